// *** design/pfbs_pkg.sv ***
// package for the program flash block switch: constants, types and function list
// Function
// - the program space is at most 64 KByte and a two-bit select field chooses which block serves its low part.
// - the primary block is 512 sectors of 128 bytes.
// - the 8K by 8 secondary block is 64 sectors of 128 bytes.
// - the low seven address bits pick the byte in a sector and the upper bits pick the sector, in both blocks.
// - with select 01, 10 or 11 every fetch address reads the primary block.
// - while hidden, the secondary block is reached only by in-application programming at 0000H to 1FFFH.
// - with select 00, fetches at 0000H to 1FFFH read the secondary block and higher ones the primary block.
// - during overlay the primary block's 0000H to 1FFFH stay reachable by in-application programming.
// - after every reset the select field is loaded from the start-up configuration bit, which only programming writes.
// - power-on or external reset gives 00 for start-up bit 1 and 01 for 0; software reset gives 10 or 11.
// - watchdog or brown-out reset keeps the upper bit and sets the lower bit to the inverse of the start-up bit.
// - software may rewrite the lower select bit at any time except during reset and on the first clock after release, without touching the start-up bit.
package pfbs_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned BYTE_W = 7;
    localparam int unsigned PRI_SECT_W = 9;
    localparam int unsigned SEC_SECT_W = 6;
    localparam int unsigned PRI_SECTORS = 512;
    localparam int unsigned SEC_SECTORS = 64;
    localparam logic [15:0] OVERLAY_TOP = 16'h1FFF;
    localparam logic [1:0] SEL_RESET = 2'h0;

    typedef enum logic [4:0] {
        RST_NONE = 5'b00001,
        RST_POR_EXT = 5'b00010,
        RST_WDT_BOD = 5'b00100,
        RST_SOFT = 5'b01000,
        RST_OTHER = 5'b10000
    } pfbs_reset_e;

    // physical flash location: block, sector, byte in sector
    typedef struct packed {
        logic blk_secondary;
        logic [PRI_SECT_W-1:0] sector;
        logic [BYTE_W-1:0] offset;
    } pfbs_loc_s;

    // access request
    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
    } pfbs_req_s;
endpackage

// *** design/pfbs_block_switch.sv ***
// program flash block switch: select field and fetch / programming address mapping
`timescale 1ns/1ps
module pfbs_block_switch
    import pfbs_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // reset cause, one cycle pulses, taken while in reset
    input wire logic i_rst_por_ext,
    input wire logic i_rst_wdt_bod,
    input wire logic i_rst_soft,
    // nonvolatile start-up configuration bit
    input wire logic i_startup_block_config_bit,
    // software write of the lower select bit
    input wire logic i_sel0_wr,
    input wire logic i_sel0_wdata,
    // instruction fetch request
    input wire pfbs_req_s i_fetch,
    // in-application programming request, secondary block flag
    input wire pfbs_req_s i_iap,
    input wire logic i_iap_secondary,
    // outputs
    output logic [1:0] o_flash_block_select_field,
    output logic o_fetch_valid,
    output pfbs_loc_s o_fetch_loc,
    output logic o_iap_valid,
    output pfbs_loc_s o_iap_loc
);

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] sel_q;
    logic [1:0] sel_d;
    pfbs_reset_e cause_q;
    pfbs_reset_e cause_d;
    logic in_reset_q;

    // latch last reset cause seen during reset; por wins over the others
    always_comb begin
        cause_d = cause_q;
        if (i_rst_por_ext) begin
            cause_d = RST_POR_EXT;
        end else if (i_rst_wdt_bod) begin
            cause_d = RST_WDT_BOD;
        end else if (i_rst_soft) begin
            cause_d = RST_SOFT;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            cause_q <= cause_d;
            in_reset_q <= 1'b1;
        end else begin
            cause_q <= RST_NONE;
            in_reset_q <= 1'b0;
        end
    end

    // select field next value
    always_comb begin
        sel_d = sel_q;
        if (in_reset_q) begin
            // strap caught on the first clock after release
            unique case (cause_q)
                RST_POR_EXT: sel_d = {1'b0, ~i_startup_block_config_bit};
                RST_WDT_BOD: sel_d = {sel_q[1], ~i_startup_block_config_bit};
                RST_SOFT: sel_d = {1'b1, ~i_startup_block_config_bit};
                RST_NONE: sel_d = {1'b0, ~i_startup_block_config_bit};
                RST_OTHER: sel_d = {1'b0, ~i_startup_block_config_bit};
                default: sel_d = {1'b0, ~i_startup_block_config_bit};
            endcase
        end else if (i_sel0_wr) begin
            // start-up bit is an input only, so it cannot be disturbed here
            sel_d = {sel_q[1], i_sel0_wdata};
        end
    end

    // upper bit survives watchdog/brown-out reset; it is cleared by power-on or external reset and by a reset with no cause pulse
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n && cause_d == RST_POR_EXT) begin
            sel_q <= SEL_RESET;
        end else begin
            sel_q <= sel_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mapping; select sampled with the request so a change hits the next fetch
    logic fetch_low;
    logic overlay;
    pfbs_loc_s fetch_map;
    pfbs_loc_s iap_map;

    assign fetch_low = (i_fetch.addr <= OVERLAY_TOP);
    assign overlay = (sel_q == 2'h0);

    always_comb begin
        fetch_map.offset = i_fetch.addr[BYTE_W-1:0];
        fetch_map.sector = i_fetch.addr[ADDR_W-1:BYTE_W];
        fetch_map.blk_secondary = overlay && fetch_low;
        if (fetch_map.blk_secondary) begin
            // secondary has 64 sectors: upper sector bits forced zero
            fetch_map.sector = {3'h0, i_fetch.addr[BYTE_W+SEC_SECT_W-1:BYTE_W]};
        end
    end

    always_comb begin
        iap_map.offset = i_iap.addr[BYTE_W-1:0];
        iap_map.sector = i_iap.addr[ADDR_W-1:BYTE_W];
        // programming reaches either block regardless of overlay
        iap_map.blk_secondary = i_iap_secondary;
        if (i_iap_secondary) begin
            iap_map.sector = {3'h0, i_iap.addr[BYTE_W+SEC_SECT_W-1:BYTE_W]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs; a fetch in flight keeps the mapping it was issued with
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_fetch_valid <= 1'b0;
            o_fetch_loc <= '0;
            o_iap_valid <= 1'b0;
            o_iap_loc <= '0;
        end else begin
            o_fetch_valid <= i_fetch.valid;
            if (i_fetch.valid) begin
                o_fetch_loc <= fetch_map;
            end
            // secondary requests above the 8K window are dropped
            o_iap_valid <= i_iap.valid && (!i_iap_secondary || i_iap.addr <= OVERLAY_TOP);
            if (i_iap.valid) begin
                o_iap_loc <= iap_map;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        o_flash_block_select_field <= sel_q;
    end

endmodule

// *** verification/pfbs_cpu.sv ***
// cpu side model: one-cycle fetch or programming requests
`timescale 1ns/1ps
module pfbs_cpu import pfbs_pkg::*; (
    input wire logic i_clk_sys,
    input wire logic i_go,
    input wire logic i_kind,
    input wire logic [15:0] i_addr,
    output pfbs_req_s o_fetch,
    output pfbs_req_s o_iap
);
    // idle address inverted so a stale one never matches
    always_ff @(posedge i_clk_sys) begin
        o_fetch <= {i_go && !i_kind, i_go ? i_addr : ~o_fetch.addr};
        o_iap <= {i_go && i_kind, i_go ? i_addr : ~o_iap.addr};
    end
endmodule

// *** verification/pfbs_chk_asserts.sv ***
// port assertions for the block switch
`timescale 1ns/1ps
module pfbs_chk import pfbs_pkg::*; (
    input wire logic i_clk_sys, i_reset_n, i_rst_por_ext, i_rst_wdt_bod, i_rst_soft,
    input wire logic i_startup_block_config_bit, i_sel0_wr, i_sel0_wdata, i_iap_secondary,
    input wire pfbs_req_s i_fetch, i_iap,
    input wire logic [1:0] o_flash_block_select_field,
    input wire logic o_fetch_valid, o_iap_valid,
    input wire pfbs_loc_s o_fetch_loc, o_iap_loc
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    a_fetch_ack: assert property (i_fetch.valid |=> o_fetch_valid) else $error("ack");
    a_fetch_blk: assert property (i_fetch.valid |=> o_fetch_loc.blk_secondary ==
        (o_flash_block_select_field == 2'h0 && $past(i_fetch.addr) < 16'h2000)) else $error("block");
    a_fetch_sect: assert property (i_fetch.valid |=> o_fetch_loc.sector == (o_fetch_loc.blk_secondary ?
        {3'h0, $past(i_fetch.addr[12:7])} : $past(i_fetch.addr[15:7]))) else $error("sector");
    a_iap_off: assert property (i_iap.valid |=> o_iap_loc.offset == $past(i_iap.addr[6:0]))
        else $error("offset");
    a_iap_blk: assert property (i_iap.valid |=> o_iap_loc.blk_secondary == $past(i_iap_secondary))
        else $error("iap block");
    a_iap_drop: assert property (i_iap.valid && i_iap_secondary && i_iap.addr > 16'h1fff |=> !o_iap_valid)
        else $error("drop");
    a_sel_write: assert property (i_sel0_wr && $past(i_reset_n) |-> ##2 o_flash_block_select_field ==
        {$past(o_flash_block_select_field[1]), $past(i_sel0_wdata, 2)}) else $error("sel write");
    a_por_load: assert property ($rose(i_reset_n) && $past(i_rst_por_ext) |-> ##2
        o_flash_block_select_field == {1'b0, ~$past(i_startup_block_config_bit, 2)}) else $error("load");
endmodule
bind pfbs_block_switch pfbs_chk u_pfbs_chk (.*);

// *** verification/tb.sv ***
// self-checking bench for the block switch
`timescale 1ns/1ps
module tb;
    import pfbs_pkg::*;
    logic i_clk_sys = 0, i_reset_n = 0, i_rst_por_ext = 0, i_rst_wdt_bod = 0, i_rst_soft = 0, go = 0, kind = 0;
    logic i_startup_block_config_bit = 1, i_sel0_wr = 0, i_sel0_wdata = 0, i_iap_secondary = 0;
    logic o_fetch_valid, o_iap_valid;
    logic [1:0] o_flash_block_select_field, sel;
    logic [15:0] addr = 0;
    logic [31:0] rs = 32'hf125_f62f;
    pfbs_req_s i_fetch, i_iap;
    pfbs_loc_s o_fetch_loc, o_iap_loc;
    int bad_count = 0, cmp_count = 0;
    always #10 i_clk_sys = ~i_clk_sys;
    pfbs_cpu u_pfbs_cpu (.i_clk_sys, .i_go(go), .i_kind(kind), .i_addr(addr), .o_fetch(i_fetch), .o_iap(i_iap));
    pfbs_block_switch u_pfbs_block_switch (.*);
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    function automatic pfbs_loc_s loc(input logic k, s, input logic [15:0] a);
        loc.blk_secondary = k ? s : sel == 2'h0 && a < 16'h2000;
        loc.sector = loc.blk_secondary ? {3'h0, a[12:7]} : a[15:7];
        loc.offset = a[6:0];
    endfunction
    task automatic chk(input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("%0d compared, %0d bad", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic req(input logic k, s, input logic [15:0] a);
        @(posedge i_clk_sys) #1 {go, kind, i_iap_secondary, addr} = {1'b1, k, s, a};
        @(posedge i_clk_sys) #1 go = 0;
        @(posedge i_clk_sys) #1;
        if (k && s && a > 16'h1fff) chk(o_iap_valid, 0);
        else chk(k ? {o_iap_loc, o_iap_valid} : {o_fetch_loc, o_fetch_valid}, {loc(k, s, a), 1'b1});
    endtask
    task automatic wsel(input logic v);
        @(posedge i_clk_sys) #1 {i_sel0_wr, i_sel0_wdata} = {1'b1, v};
        @(posedge i_clk_sys) #1 i_sel0_wr = 0;
        sel[0] = v;
        @(posedge i_clk_sys) #1 chk(o_flash_block_select_field, sel);
    endtask
    // cause 0 power-on, 1 software, 2 watchdog: watchdog last so a kept upper bit of 1 is seen
    task automatic rst(input int n, c, input logic b);
        @(posedge i_clk_sys) #1 {i_reset_n, i_rst_por_ext, i_rst_soft, i_rst_wdt_bod} = {1'b0, c == 0, c == 1, c == 2};
        i_startup_block_config_bit = b;
        repeat (n) @(posedge i_clk_sys);
        #1 {i_reset_n, i_rst_por_ext, i_rst_soft, i_rst_wdt_bod} = 4'h8;
        sel = {c == 0 ? 1'b0 : c == 1 ? 1'b1 : sel[1], ~b};
        repeat (2) @(posedge i_clk_sys);
        #1 chk(o_flash_block_select_field, sel);
    endtask
    initial begin
        rst(10, 0, 1);
        for (int c = 0; c < 3; c++) begin
            for (int b = 0; b < 2; b++) begin
                rst(2, c, b[0]);
                req(0, 0, 16'h1fff);
                req(0, 0, 16'h2000);
                req(1, !sel[0], 16'h0000);
            end
        end
        rst(2, 0, 1);
        repeat (300) begin
            rs = xs(rs);
            // select writes only between fetches, on one draw in 16, whatever the last address
            if (rs[3:0] == 4'h0) wsel(rs[4]);
            else req(rs[5], rs[6], rs[31:16]);
        end
        conclude;
    end
    initial begin
        #100000;
        bad_count++;
        conclude;
    end
endmodule
